/* src/dvs_regs_pkg.sv */
// package: constants and types for the dvs regulator serial register bank
package dvs_regs_pkg;

  // ----------------------------------------
  // slave address and register offsets
  // ----------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h5B; // 8-bit forms B6 write, B7 read
  localparam logic [2:0] OFF_CTRL = 3'h1; // control_and_flags
  localparam logic [2:0] OFF_LVL_LO = 3'h2; // level_code_select_low
  localparam logic [2:0] OFF_LVL_HI = 3'h3; // level_code_select_high

  // ----------------------------------------
  // field positions and defaults
  // ----------------------------------------
  localparam int BIT_REG_ENABLE = 0;
  localparam int BIT_LONG_RAMP = 1;
  localparam int BIT_IN_RANGE = 4;
  localparam int BIT_LOW_INPUT = 5;
  localparam int BIT_OVERHEAT = 6;
  localparam logic [7:0] CTRL_RW_MASK = 8'h0F; // bits 3:0 writable
  localparam logic [7:0] CTRL_DEFAULT = 8'h01; // regulator enabled, short ramp
  localparam logic [7:0] LVL_LO_DEFAULT = 8'h1E;
  localparam logic [7:0] LVL_HI_DEFAULT = 8'h0A;
  localparam logic [7:0] LVL_MAX = 8'hAA; // 170 -> 2.4 V
  localparam int LVL_BASE_MV = 700; // target = 700 mV + 10 mV * code
  localparam int LVL_STEP_MV = 10;

  // ----------------------------------------
  // serial engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_RACK = 3'b101
  } ser_state_e;

  // synchronised pin samples, three stages each
  typedef struct packed {
    logic [2:0] scl;
    logic [2:0] sda;
    logic [2:0] en;
    logic [2:0] sel;
  } pin_sync_s;

  // live status inputs from the analog side
  typedef struct packed {
    logic overheat;
    logic low_input;
    logic in_range;
  } status_s;

endpackage : dvs_regs_pkg

/* src/dvs_regulator_i2c_regs.sv */
// module: two-wire serial slave with the regulator control register bank
`timescale 1ns/1ps
`default_nettype none
module dvs_regulator_i2c_regs (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // serial pins, data is open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // chip enable and voltage_select_pin
  input wire logic chip_en_i,
  input wire logic voltage_select_pin_i,
  // analog status
  input wire dvs_regs_pkg::status_s status_i,
  // regulator controls
  output logic regulator_on_o,
  output logic long_ramp_bit_o,
  output logic [7:0] level_code_o,
  output logic [11:0] target_mv_o,
  output logic ramped_level_change_o
);
  import dvs_regs_pkg::*;
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pin_sync_s pins;         // three-stage synchronisers
    logic scl_s;             // agreed scl level
    logic sda_s;             // agreed sda level
    logic en_s;              // agreed chip enable level
    logic sel_s;             // agreed select level
    ser_state_e st;          // serial engine state
    logic [3:0] bitn;        // bit counter
    logic [7:0] shreg;       // shift register
    logic [1:0] bytn;        // byte index in write
    logic rd;                // current transfer is a read
    logic [2:0] ptr;         // register pointer
    logic [7:0] ctrl;        // writable bits 3:0
    logic overheat;          // sticky overheat flag
    logic [7:0] lvl_lo;
    logic [7:0] lvl_hi;
    logic sda_oe;
    logic ramp;
    logic [7:0] code;
    logic [11:0] mv;
  } state_s;
  state_s q, d;
  // clamp a code to the top usable value
  function automatic logic [7:0] clamp_code(input logic [7:0] c);
    clamp_code = (c > LVL_MAX) ? LVL_MAX : c;
  endfunction : clamp_code
  // read mux of the register bank
  function automatic logic [7:0] rd_reg(input state_s s, input status_s st);
    rd_reg = 8'h00; // unmapped reads zero
    if (s.ptr == OFF_CTRL)
    begin
      rd_reg = s.ctrl & CTRL_RW_MASK; // bit 7 always zero
      rd_reg[BIT_OVERHEAT] = s.overheat;
      rd_reg[BIT_LOW_INPUT] = st.low_input;
      rd_reg[BIT_IN_RANGE] = st.in_range;
    end
    else if (s.ptr == OFF_LVL_LO)
      rd_reg = s.lvl_lo;
    else if (s.ptr == OFF_LVL_HI)
      rd_reg = s.lvl_hi;
  endfunction : rd_reg
  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic [7:0] nb;
    logic [7:0] sel_code;
    logic [7:0] rv;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    nb = 8'h00;
    sel_code = q.sel_s ? q.lvl_hi : q.lvl_lo; // selected code
    rv = rd_reg(q, status_i); // byte a read would send next
    d = q;
    // shift pins in; a change counts when stages 2 and 3 agree
    d.pins.scl = {q.pins.scl[1:0], scl_i};
    d.pins.sda = {q.pins.sda[1:0], sda_i};
    d.pins.en = {q.pins.en[1:0], chip_en_i};
    d.pins.sel = {q.pins.sel[1:0], voltage_select_pin_i};
    if (q.pins.scl[1] == q.pins.scl[2])
      d.scl_s = q.pins.scl[2];
    if (q.pins.sda[1] == q.pins.sda[2])
      d.sda_s = q.pins.sda[2];
    if (q.pins.en[1] == q.pins.en[2])
      d.en_s = q.pins.en[2];
    if (q.pins.sel[1] == q.pins.sel[2])
      d.sel_s = q.pins.sel[2];
    // edges of the agreed levels; scl is a sampled input, not a clock
    scl_rise = d.scl_s & ~q.scl_s;
    scl_fall = ~d.scl_s & q.scl_s;
    start = q.scl_s & d.scl_s & q.sda_s & ~d.sda_s;
    stop = q.scl_s & d.scl_s & ~q.sda_s & d.sda_s;
    d.ramp = 1'b0;
    // overheat is sticky until the bank clears
    if (status_i.overheat)
      d.overheat = 1'b1;
    // serial engine; master owns lines except ack/read bits
    if (start)
    begin
      d.st = ST_ADDR; // repeated start also lands here
      d.bitn = 4'h0;
      d.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      d.st = ST_IDLE;
      d.sda_oe = 1'b0;
    end
    else
    begin
      case (q.st)
        ST_ADDR, ST_WDATA:
        begin
          if (scl_rise)
          begin
            d.shreg = {q.shreg[6:0], q.sda_s};
            d.bitn = q.bitn + 4'h1;
          end
          if (scl_fall && q.bitn == 4'h8)
          begin
            nb = q.shreg;
            d.bitn = 4'h0;
            if (q.st == ST_ADDR)
            begin
              if (nb[7:1] == SLAVE_ADDR)
              begin
                d.rd = nb[0];
                d.bytn = 2'h0;
                d.sda_oe = 1'b1;
                d.st = ST_ACK;
              end
              else
                d.st = ST_IDLE;
            end
            else
            begin
              d.sda_oe = 1'b1; // every byte acked, even unmapped
              d.st = ST_ACK;
              if (q.bytn == 2'h0)
                d.ptr = nb[2:0]; // only three low bits
              else if (q.ptr == OFF_CTRL)
                d.ctrl = nb & CTRL_RW_MASK; // status bits untouched
              else if (q.ptr == OFF_LVL_LO)
              begin
                d.lvl_lo = clamp_code(nb);
                d.ramp = q.ctrl[BIT_REG_ENABLE] & ~q.sel_s;
              end
              else if (q.ptr == OFF_LVL_HI)
              begin
                d.lvl_hi = clamp_code(nb);
                d.ramp = q.ctrl[BIT_REG_ENABLE] & q.sel_s;
              end
              if (q.bytn != 2'h0)
                d.ptr = q.ptr + 3'h1; // later bytes go to the next register
              if (q.bytn != 2'h3)
                d.bytn = q.bytn + 2'h1;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            if (q.rd)
            begin
              d.shreg = rv;
              d.sda_oe = ~rv[7]; // low bit drives
              d.bitn = 4'h1;
              d.st = ST_RDATA;
            end
            else
            begin
              d.sda_oe = 1'b0;
              d.bitn = 4'h0;
              d.st = ST_WDATA;
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (q.bitn == 4'h8)
            begin
              d.sda_oe = 1'b0;
              d.st = ST_RACK;
            end
            else
            begin
              d.shreg = {q.shreg[6:0], 1'b0};
              d.sda_oe = ~q.shreg[6];
              d.bitn = q.bitn + 4'h1;
            end
          end
        end
        ST_RACK:
        begin
          // master ack asks for another byte; nack ends the read
          if (scl_rise)
          begin
            if (q.sda_s)
              d.st = ST_IDLE;
            else
            begin
              d.ptr = q.ptr + 3'h1;
              d.st = ST_ACK;
            end
          end
        end
        default:
          d.st = ST_IDLE;
      endcase
    end
    // output target from the selected code
    d.code = sel_code;
    d.mv = 12'(LVL_BASE_MV + LVL_STEP_MV * int'(sel_code));
    if (q.sel_s != d.sel_s && q.ctrl[BIT_REG_ENABLE])
      d.ramp = 1'b1; // pin flip also moves the target
    // chip enable: low holds zero, rising edge loads defaults
    if (!q.en_s)
    begin
      d.ctrl = 8'h00;
      d.lvl_lo = 8'h00;
      d.lvl_hi = 8'h00;
      d.overheat = 1'b0;
      d.st = ST_IDLE;
      d.sda_oe = 1'b0;
      d.ramp = 1'b0;
      if (d.en_s)
      begin
        d.ctrl = CTRL_DEFAULT;
        d.lvl_lo = LVL_LO_DEFAULT;
        d.lvl_hi = LVL_HI_DEFAULT;
      end
    end
  end
  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      q <= '0;
      q.pins <= '{scl: 3'b111, sda: 3'b111, en: 3'b000, sel: 3'b000}; // idle lines high
      q.scl_s <= 1'b1;
      q.sda_s <= 1'b1;
    end
    else
      q <= d;
  end
  // ----------------------------------------
  // outputs from flops, except sda_o tied low
  // ----------------------------------------
  assign sda_o = 1'b0;
  assign sda_oe_o = q.sda_oe;
  assign regulator_on_o = q.ctrl[BIT_REG_ENABLE];
  assign long_ramp_bit_o = q.ctrl[BIT_LONG_RAMP];
  assign level_code_o = q.code;
  assign target_mv_o = q.mv;
  assign ramped_level_change_o = q.ramp;
endmodule : dvs_regulator_i2c_regs
`default_nettype wire

/* verif/dvs_regs_checker.sv */
// checker: port assertions for the regulator register bank
`timescale 1ns/1ps
`default_nettype none
module dvs_regs_checker
  import dvs_regs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic chip_en_i,
  input wire logic regulator_on_o,
  input wire logic [7:0] level_code_o,
  input wire logic [11:0] target_mv_o,
  input wire logic ramped_level_change_o
);
  // ----------------------------------------
  // single clock domain
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // enable held off long enough to pass the pin synchroniser
  sequence s_en_off;
    !chip_en_i [*8];
  endsequence
  // code steady two edges, nonzero so the cleared state is excluded
  sequence s_code_settled;
    $stable(level_code_o) ##1 $stable(level_code_o) && level_code_o != 8'h00;
  endsequence
  a_target_from_code: assert property (s_code_settled |->
    target_mv_o == 12'(LVL_BASE_MV + LVL_STEP_MV * level_code_o)) else $error("target off");
  a_code_capped: assert property (level_code_o <= LVL_MAX)
    else $error("code above max");
  a_en_off_clear: assert property (s_en_off |->
    !regulator_on_o && level_code_o == 8'h00 && !sda_oe_o) else $error("not cleared");
  a_ramp_when_on: assert property (ramped_level_change_o |-> regulator_on_o)
    else $error("ramp while off");
  a_ramp_single: assert property (ramped_level_change_o |=> !ramped_level_change_o)
    else $error("ramp longer than one cycle");
  a_ack_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("drive while clock high");
  a_ack_holds: assert property ($rose(sda_oe_o) |=> sda_oe_o [*8])
    else $error("drive too short");
  a_drain_low: assert property (sda_o == 1'b0)
    else $error("data value not low");
endmodule : dvs_regs_checker
bind dvs_regulator_i2c_regs dvs_regs_checker i_chk (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .chip_en_i(chip_en_i), .regulator_on_o(regulator_on_o),
  .level_code_o(level_code_o), .target_mv_o(target_mv_o),
  .ramped_level_change_o(ramped_level_change_o)
);
`default_nettype wire

/* verif/i2c_master_model.sv */
// partner: two-wire bus master model
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  // system clock for alignment, resolved data line
  input wire logic clk_sys_i,
  input wire logic sda_line_i,
  // master drives
  output logic scl_o,
  output logic sda_low_o
);
  // idle: clock stands high, data released
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // one bit; 40 ns quarters keep changes aligned to falling clock edges
  task automatic bitx(input logic b, output logic r);
    sda_low_o = ~b;
    #40 scl_o = 1'b1;
    #40 r = sda_line_i;
    #40 scl_o = 1'b0;
    #40;
  endtask : bitx
  // start or repeated start
  task automatic start;
    @(negedge clk_sys_i);
    sda_low_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 sda_low_o = 1'b1;
    #40 scl_o = 1'b0;
    #40;
  endtask : start
  task automatic stop;
    sda_low_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 sda_low_o = 1'b0;
    #40;
  endtask : stop
  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r,
                      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bitx(w[i], r[i]);
    bitx(last, a);
    ack = ~a;
  endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

/* verif/dvs_regulator_i2c_regs_test.sv */
// testbench: scenarios for the regulator register bank
`timescale 1ns/1ps
`default_nettype none
module dvs_regulator_i2c_regs_test;
  import dvs_regs_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic chip_en_i = 1'b0;
  logic sel = 1'b0;
  status_s status = '0;
  logic scl, m_low, sda_o, sda_oe_o, sda_line, reg_on, long_ramp, ramp;
  logic [7:0] code;
  logic [11:0] mv;
  int failures = 0;
  int checked = 0;
  int ramps = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  // open drain data line with pull-up
  assign sda_line = ~(m_low | (sda_oe_o & ~sda_o));
  always @(posedge clk_sys_i)
    if (ramp === 1'b1)
      ramps++;
  i2c_master_model i_master (.clk_sys_i(clk_sys_i), .sda_line_i(sda_line), .scl_o(scl),
    .sda_low_o(m_low));
  dvs_regulator_i2c_regs i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_en_i(chip_en_i),
    .voltage_select_pin_i(sel), .status_i(status), .regulator_on_o(reg_on),
    .long_ramp_bit_o(long_ramp), .level_code_o(code), .target_mv_o(mv),
    .ramped_level_change_o(ramp));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [7:0] b, input logic ack_exp);
    logic [7:0] r;
    logic a;
    i_master.xfer(b, 1'b1, r, a);
    chk(a, ack_exp);
  endtask : send
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    i_master.start();
    send(8'hB6, 1'b1);
    send(ra, 1'b1);
    send(d, 1'b1);
    i_master.stop();
  endtask : wr
  task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
    logic [7:0] r;
    logic a;
    i_master.start();
    send(8'hB6, 1'b1);
    send(ra, 1'b1);
    i_master.start();
    send(8'hB7, 1'b1);
    i_master.xfer(8'hFF, 1'b1, r, a);
    i_master.stop();
    chk(r, exp);
  endtask : rd
  task automatic t_defaults;
    chk(code, 8'h1E);
    chk(mv, 12'd1000);
    chk({reg_on, long_ramp}, 2'b10);
    rd(8'h01, 8'h01);
    rd(8'h02, 8'h1E);
    rd(8'h03, 8'h0A);
  endtask : t_defaults
  task automatic t_dvs;
    wr(8'h02, 8'h6E);
    chk(code, 8'h6E);
    chk(mv, 12'd1800);
    chk(ramps, 1);
    @(negedge clk_sys_i) sel = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    chk(code, 8'h0A);
    wr(8'h03, 8'hC8);
    chk(code, LVL_MAX);
    rd(8'h03, 8'hAA);
    wr(8'h02, 8'h20);
    chk(ramps, 3);
  endtask : t_dvs
  task automatic t_decode;
    wr(8'h0A, 8'h33);
    rd(8'h02, 8'h33);
    wr(8'h04, 8'h55);
    rd(8'h04, 8'h00);
    rd(8'h07, 8'h00);
  endtask : t_decode
  // two data bytes in one write, then a two-byte read with master ack
  task automatic t_burst;
    logic [7:0] r;
    logic a;
    i_master.start();
    send(8'hB6, 1'b1);
    send(8'h02, 1'b1);
    send(8'h44, 1'b1);
    send(8'h55, 1'b1);
    i_master.stop();
    i_master.start();
    send(8'hB6, 1'b1);
    send(8'h02, 1'b1);
    i_master.start();
    send(8'hB7, 1'b1);
    i_master.xfer(8'hFF, 1'b0, r, a);
    chk(r, 8'h44);
    i_master.xfer(8'hFF, 1'b1, r, a);
    i_master.stop();
    chk(r, 8'h55);
    chk(code, 8'h55);
  endtask : t_burst
  task automatic t_status;
    @(negedge clk_sys_i) status = '1;
    rd(8'h01, 8'h71);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h7F);
    chk(long_ramp, 1'b1);
    wr(8'h01, 8'h00);
    chk(reg_on, 1'b0);
    @(negedge clk_sys_i) status = '0;
    rd(8'h01, 8'h40);
    ramps = 0;
    wr(8'h03, 8'h50);
    chk(ramps, 0);
    chk(code, 8'h50);
  endtask : t_status
  task automatic t_bad_addr;
    i_master.start();
    send(8'hB4, 1'b0);
    i_master.stop();
  endtask : t_bad_addr
  task automatic t_chip_en;
    @(negedge clk_sys_i) chip_en_i = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    chk(code, 8'h00);
    chip_en_i = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    chk(code, 8'h0A);
    rd(8'h01, 8'h01);
  endtask : t_chip_en
  task automatic results;
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  initial
  begin
    repeat (5) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    @(negedge clk_sys_i) chip_en_i = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    t_defaults();
    t_dvs();
    t_decode();
    t_burst();
    t_status();
    t_bad_addr();
    t_chip_en();
    results();
  end
  // watchdog well beyond the expected run of about 120 us
  initial
  begin
    #500000;
    failures++;
    results();
  end
endmodule : dvs_regulator_i2c_regs_test
`default_nettype wire
